// ===== core/qsw_pkg.sv
package qsw_pkg;

  // ----------------------------------------------------------------
  // command word layout
  // ----------------------------------------------------------------
  localparam int WORD_W       = 16;
  localparam int WDOG_BIT     = 15;
  localparam int ADDR_HI      = 14;
  localparam int ADDR_LO      = 10;
  localparam int CHAN_HI      = 14;
  localparam int CHAN_LO      = 13;
  localparam int REG_HI       = 12;
  localparam int REG_LO       = 10;
  localparam int DATA_W       = 9;
  localparam int SEL_W        = 5;
  localparam int NUM_CHAN     = 4;
  localparam int CHAN_W       = 2;
  localparam int BITCNT_W     = 4;

  // ----------------------------------------------------------------
  // register codes (low three address bits)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_STATUS_SEL = 3'h0;
  localparam logic [2:0] REG_PWM_STATE  = 3'h1;
  localparam logic [2:0] REG_SWITCHING  = 3'h2;
  localparam logic [2:0] REG_FAULT      = 3'h3;
  localparam logic [2:0] REG_OVERCUR    = 3'h4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 9'h000;
  localparam logic [SEL_W-1:0]  SEL_RST  = 5'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PWM_PROFILE_BIT = 8;
  localparam int PWM_ON_BIT      = 7;
  localparam int PWM_DUTY_HI     = 6;
  localparam int SW_DIRDIS_BIT   = 5;
  localparam int SW_SLEW_HI      = 4;
  localparam int SW_SLEW_LO      = 3;
  localparam int SW_DELAY_HI     = 2;
  localparam int FM_RETRY_UNL    = 6;
  localparam int FM_RETRY_DIS    = 5;
  localparam int FM_SHORT_DIS    = 4;
  localparam int FM_ONOL_DIS     = 3;
  localparam int FM_OFFOL_DIS    = 2;
  localparam int FM_LED_THR      = 1;
  localparam int FM_SENSE_RATIO  = 0;
  localparam int OC_ALT_PROFILE  = 8;
  localparam int OC_COOL_HI      = 7;
  localparam int OC_COOL_LO      = 6;
  localparam int OC_INRUSH_HI    = 5;
  localparam int OC_INRUSH_LO    = 4;
  localparam int OC_HI_SWAP      = 3;
  localparam int OC_STEADY_HI    = 2;
  localparam int OC_STEADY_LO    = 1;
  localparam int OC_MODE_BIT     = 0;

  // ----------------------------------------------------------------
  // decoded selections
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    QSW_SLEW_MEDIUM = 2'b00,
    QSW_SLEW_LOW    = 2'b01,
    QSW_SLEW_HIGH   = 2'b10,
    QSW_SLEW_UNUSED = 2'b11
  } qsw_slew_t;

  typedef enum logic [1:0] {
    QSW_ONOL_BULB = 2'b00,
    QSW_ONOL_LED  = 2'b01,
    QSW_ONOL_OFF  = 2'b10
  } qsw_onol_t;

endpackage

// ===== core/qsw_regs.sv
`timescale 1ns/10ps
`default_nettype none

module qsw_regs
  import qsw_pkg::*;
(
  // system
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      supply_fail,
  // serial link
  input  wire logic                      sclk,
  input  wire logic                      cs_n,
  input  wire logic                      sdi,
  // global controls
  input  wire logic                      pwm_enable,
  input  wire logic [NUM_CHAN-1:0]       direct_in,
  // readback selection
  output logic      [SEL_W-1:0]          status_read_select,
  output logic                           watchdog_toggle_bit,
  // per-channel decoded settings
  output logic      [NUM_CHAN-1:0]       chan_on,
  output logic      [NUM_CHAN-1:0]       reduced_lamp_profile,
  output logic      [NUM_CHAN*7-1:0]     duty_cycle_field,
  output logic      [NUM_CHAN*3-1:0]     switch_delay_field,
  output logic      [NUM_CHAN*2-1:0]     slew_select,
  output logic      [NUM_CHAN-1:0]       retry_counter_disable,
  output logic      [NUM_CHAN-1:0]       retry_disable,
  output logic      [NUM_CHAN-1:0]       short_to_battery_disable,
  output logic      [NUM_CHAN*2-1:0]     on_openload_mode,
  output logic      [NUM_CHAN-1:0]       off_openload_disable,
  output logic      [NUM_CHAN-1:0]       sense_ratio_select,
  output logic      [NUM_CHAN-1:0]       alt_lamp_profile,
  output logic      [NUM_CHAN*2-1:0]     cooling_curve,
  output logic      [NUM_CHAN*2-1:0]     inrush_curve,
  output logic      [NUM_CHAN-1:0]       high_level_swap,
  output logic      [NUM_CHAN*2-1:0]     steady_limit,
  output logic      [NUM_CHAN-1:0]       overcurrent_mode_select,
  // raw register images, channel n at [n*9 +: 9]
  output logic      [NUM_CHAN*DATA_W-1:0] output_pwm_state,
  output logic      [NUM_CHAN*DATA_W-1:0] output_switching_config,
  output logic      [NUM_CHAN*DATA_W-1:0] output_fault_config,
  output logic      [NUM_CHAN*DATA_W-1:0] output_overcurrent_config
);

  // ----------------------------------------------------------------
  // combined reset: pin or supply loss
  // ----------------------------------------------------------------
  logic fail_s1_q;
  logic fail_s2_q;
  logic clr_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fail_s1_q <= 1'b0;
      fail_s2_q <= 1'b0;
    end else begin
      fail_s1_q <= supply_fail;
      fail_s2_q <= fail_s1_q;
    end
  end

  assign clr_n = rstn & ~fail_s2_q;

  // ----------------------------------------------------------------
  // link domain: shift in, count, capture on cs rise
  // ----------------------------------------------------------------
  logic [WORD_W-1:0]   shift_q;
  logic [BITCNT_W-1:0] bitcnt_q;
  logic                any_bit_q;
  logic [WORD_W-1:0]   word_q;
  logic                word_tgl_q;

  // cs_n high holds the counter in reset so every frame starts clean
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bitcnt_q  <= '0;
      any_bit_q <= 1'b0;
    end else begin
      bitcnt_q  <= bitcnt_q + 1'b1;
      any_bit_q <= 1'b1;
    end
  end

  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= '0;
    end else if (!cs_n) begin
      shift_q <= {shift_q[WORD_W-2:0], sdi};
    end
  end

  // the rising cs_n edge closes the frame; sclk is stopped there
  always_ff @(posedge cs_n or negedge rstn) begin
    if (!rstn) begin
      word_q     <= '0;
      word_tgl_q <= 1'b0;
    end else if (any_bit_q && bitcnt_q == '0) begin
      word_q     <= shift_q;
      word_tgl_q <= ~word_tgl_q;
    end
  end

  // ----------------------------------------------------------------
  // crossing: toggle synchroniser, word is stable when seen
  // ----------------------------------------------------------------
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic word_ev;

  // only the pin reset clears the toggle chain: supply loss must not
  // fake a toggle edge that would replay the last word after recovery
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= word_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  assign word_ev = tgl_s2_q ^ tgl_s3_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [ADDR_HI-ADDR_LO:0] addr;
  logic [2:0]               reg_code;
  logic [CHAN_W-1:0]        chan;
  logic [DATA_W-1:0]        wdata;

  assign addr     = word_q[ADDR_HI:ADDR_LO];
  assign reg_code = addr[REG_HI-ADDR_LO:0];
  assign chan     = word_q[CHAN_HI:CHAN_LO];
  assign wdata    = word_q[DATA_W-1:0];

  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      watchdog_toggle_bit <= 1'b0;
    end else if (word_ev) begin
      watchdog_toggle_bit <= word_q[WDOG_BIT];
    end
  end

  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      status_read_select <= SEL_RST;
    end else if (word_ev && reg_code == REG_STATUS_SEL) begin
      status_read_select <= wdata[SEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // per-channel register copies and decoded settings
  // ----------------------------------------------------------------
  logic [NUM_CHAN-1:0] din_s1_q;
  logic [NUM_CHAN-1:0] din_s2_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
    end else begin
      din_s1_q <= direct_in;
      din_s2_q <= din_s1_q;
    end
  end

  logic pen_s1_q;
  logic pen_s2_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pen_s1_q <= 1'b0;
      pen_s2_q <= 1'b0;
    end else begin
      pen_s1_q <= pwm_enable;
      pen_s2_q <= pen_s1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      logic [DATA_W-1:0] pwm_q;
      logic [DATA_W-1:0] sw_q;
      logic [DATA_W-1:0] fm_q;
      logic [DATA_W-1:0] oc_q;
      logic              hit;

      assign hit = word_ev && chan == CHAN_W'(g);

      always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
          pwm_q <= DATA_RST;
        end else if (hit && reg_code == REG_PWM_STATE) begin
          pwm_q <= wdata;
        end
      end

      always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
          sw_q <= DATA_RST;
        end else if (hit && reg_code == REG_SWITCHING) begin
          sw_q <= wdata;
        end
      end

      always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
          fm_q <= DATA_RST;
        end else if (hit && reg_code == REG_FAULT) begin
          fm_q <= wdata;
        end
      end

      always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
          oc_q <= DATA_RST;
        end else if (hit && reg_code == REG_OVERCUR) begin
          oc_q <= wdata;
        end
      end

      assign output_pwm_state[g*DATA_W +: DATA_W]          = pwm_q;
      assign output_switching_config[g*DATA_W +: DATA_W]   = sw_q;
      assign output_fault_config[g*DATA_W +: DATA_W]       = fm_q;
      assign output_overcurrent_config[g*DATA_W +: DATA_W] = oc_q;

      // direct pin is honoured unless disabled or the pwm module owns the output
      assign chan_on[g] = pwm_q[PWM_ON_BIT]
                        | (din_s2_q[g] & ~sw_q[SW_DIRDIS_BIT] & ~pen_s2_q);
      assign reduced_lamp_profile[g] = pwm_q[PWM_PROFILE_BIT];
      assign duty_cycle_field[g*7 +: 7] =
        pen_s2_q ? pwm_q[PWM_DUTY_HI:0] : 7'h00;
      assign switch_delay_field[g*3 +: 3] =
        pen_s2_q ? sw_q[SW_DELAY_HI:0] : 3'h0;
      assign slew_select[g*2 +: 2] = sw_q[SW_SLEW_HI:SW_SLEW_LO];

      assign retry_counter_disable[g]    = fm_q[FM_RETRY_UNL];
      assign retry_disable[g]            = fm_q[FM_RETRY_DIS];
      assign short_to_battery_disable[g] = fm_q[FM_SHORT_DIS];
      assign on_openload_mode[g*2 +: 2]  =
        fm_q[FM_ONOL_DIS] ? QSW_ONOL_OFF :
        (fm_q[FM_LED_THR] ? QSW_ONOL_LED : QSW_ONOL_BULB);
      assign off_openload_disable[g]     = fm_q[FM_OFFOL_DIS];
      assign sense_ratio_select[g]       = fm_q[FM_SENSE_RATIO];

      assign alt_lamp_profile[g]        = oc_q[OC_ALT_PROFILE];
      assign cooling_curve[g*2 +: 2]    = oc_q[OC_COOL_HI:OC_COOL_LO];
      assign inrush_curve[g*2 +: 2]     = oc_q[OC_INRUSH_HI:OC_INRUSH_LO];
      assign high_level_swap[g]         = oc_q[OC_HI_SWAP];
      assign steady_limit[g*2 +: 2]     = oc_q[OC_STEADY_HI:OC_STEADY_LO];
      assign overcurrent_mode_select[g] = oc_q[OC_MODE_BIT];
    end
  endgenerate

endmodule

`default_nettype wire

// ===== tb/qsw_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module qsw_host_model (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b1;
  end

  // shifts the low n bits msb first; the clock runs only inside the frame
  task automatic send(input logic [47:0] bits, input int n);
    #7 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = bits[i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 cs_n = 1'b1;
    // a released line must not keep showing the last bit
    sdi = ~sdi;
    #64;
  endtask
endmodule

`default_nettype wire

// ===== tb/qsw_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none

module qsw_regs_checker
  import qsw_pkg::*;
(
  // system
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire logic                       supply_fail,
  input wire logic                       cs_n,
  input wire logic                       pwm_enable,
  input wire logic [NUM_CHAN-1:0]        direct_in,
  // outputs
  input wire logic [SEL_W-1:0]           status_read_select,
  input wire logic [NUM_CHAN-1:0]        chan_on,
  input wire logic [NUM_CHAN-1:0]        reduced_lamp_profile,
  input wire logic [NUM_CHAN*7-1:0]      duty_cycle_field,
  input wire logic [NUM_CHAN*3-1:0]      switch_delay_field,
  input wire logic [NUM_CHAN*2-1:0]      on_openload_mode,
  input wire logic [NUM_CHAN*2-1:0]      steady_limit,
  input wire logic [NUM_CHAN*DATA_W-1:0] output_pwm_state,
  input wire logic [NUM_CHAN*DATA_W-1:0] output_switching_config,
  input wire logic [NUM_CHAN*DATA_W-1:0] output_fault_config,
  input wire logic [NUM_CHAN*DATA_W-1:0] output_overcurrent_config
);
  logic [1:0]            up_q;
  logic [2:0]            quiet_q;
  logic [NUM_CHAN-1:0]   on_x, dis_x, lamp_x;
  logic [NUM_CHAN*7-1:0] duty_x;
  logic [NUM_CHAN*3-1:0] dly_x;
  logic [NUM_CHAN*2-1:0] onol_x, lim_x;

  // synchronisers need two edges after reset before $past is meaningful
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end

  // cycles with no frame and no supply loss in flight
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) quiet_q <= 3'h0;
    else if (!cs_n || supply_fail) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      on_x[i] = output_pwm_state[i*DATA_W+PWM_ON_BIT];
      lamp_x[i] = output_pwm_state[i*DATA_W+PWM_PROFILE_BIT];
      duty_x[i*7+:7] = output_pwm_state[i*DATA_W+:7];
      dis_x[i] = output_switching_config[i*DATA_W+SW_DIRDIS_BIT];
      dly_x[i*3+:3] = output_switching_config[i*DATA_W+:3];
      onol_x[i*2+:2] = output_fault_config[i*DATA_W+FM_ONOL_DIS] ? 2'h2 :
                       {1'b0, output_fault_config[i*DATA_W+FM_LED_THR]};
      lim_x[i*2+:2] = output_overcurrent_config[i*DATA_W+OC_STEADY_LO+:2];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chan_on_a: assert property (up_q == 2'h3 |-> chan_on ==
    (on_x | ($past(direct_in, 2) & ~dis_x & {NUM_CHAN{!$past(pwm_enable, 2)}})))
    else $error("channel on state wrong");
  duty_gate_a: assert property (up_q == 2'h3 |->
    duty_cycle_field == ($past(pwm_enable, 2) ? duty_x : '0)) else $error("duty gating wrong");
  delay_gate_a: assert property (up_q == 2'h3 |->
    switch_delay_field == ($past(pwm_enable, 2) ? dly_x : '0)) else $error("delay gating wrong");
  hold_quiet_a: assert property (quiet_q == 3'h7 |-> $stable(status_read_select) &&
    $stable(output_pwm_state) && $stable(output_switching_config) &&
    $stable(output_fault_config) && $stable(output_overcurrent_config))
    else $error("register changed without a frame");
  fail_clear_a: assert property (supply_fail [*3] |=> output_pwm_state == '0 &&
    output_fault_config == '0 && status_read_select == '0) else $error("supply loss kept data");
  reset_clear_a: assert property ($rose(rstn) |-> output_switching_config == '0 &&
    output_overcurrent_config == '0 && output_pwm_state == '0) else $error("reset value wrong");
  lamp_map_a: assert property (reduced_lamp_profile == lamp_x)
    else $error("lamp profile wrong");
  onol_map_a: assert property (on_openload_mode == onol_x)
    else $error("on openload mode wrong");
  limit_map_a: assert property (steady_limit == lim_x)
    else $error("steady limit wrong");

  frame_c: cover property ($rose(cs_n));
  fail_c: cover property (supply_fail [*3]);
  pwm_c: cover property ($past(pwm_enable, 2) && duty_cycle_field != '0);
endmodule

bind qsw_regs qsw_regs_checker i_chk (
  .clk(clk), .rstn(rstn), .supply_fail(supply_fail), .cs_n(cs_n), .pwm_enable(pwm_enable),
  .direct_in(direct_in), .status_read_select(status_read_select), .chan_on(chan_on),
  .reduced_lamp_profile(reduced_lamp_profile), .duty_cycle_field(duty_cycle_field),
  .switch_delay_field(switch_delay_field), .on_openload_mode(on_openload_mode),
  .steady_limit(steady_limit), .output_pwm_state(output_pwm_state),
  .output_switching_config(output_switching_config), .output_fault_config(output_fault_config),
  .output_overcurrent_config(output_overcurrent_config)
);

`default_nettype wire

// ===== tb/test_quad_switch_output_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module test_quad_switch_output_config_regs
  import qsw_pkg::*;
;
  logic                       clk = 1'b0;
  logic                       rstn = 1'b0;
  logic                       supply_fail = 1'b0;
  logic                       pwm_enable = 1'b0;
  logic [NUM_CHAN-1:0]        direct_in = '0;
  wire                        sclk, cs_n, sdi;
  logic [SEL_W-1:0]           status_read_select;
  logic                       watchdog_toggle_bit;
  logic [NUM_CHAN-1:0]        chan_on;
  logic [NUM_CHAN*7-1:0]      duty_cycle_field;
  logic [NUM_CHAN*DATA_W-1:0] output_pwm_state, output_switching_config;
  logic [NUM_CHAN*DATA_W-1:0] output_fault_config, output_overcurrent_config;
  logic [DATA_W-1:0]          ep [NUM_CHAN] = '{default: '0};
  logic [DATA_W-1:0]          es [NUM_CHAN] = '{default: '0};
  logic [DATA_W-1:0]          ef [NUM_CHAN] = '{default: '0};
  logic [DATA_W-1:0]          eo [NUM_CHAN] = '{default: '0};
  logic [SEL_W-1:0]           esel = '0;
  int                         err_total = 0;
  int                         cmp_count = 0;

  always #5 clk = ~clk;

  qsw_host_model i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  qsw_regs i_dut (
    .clk(clk), .rstn(rstn), .supply_fail(supply_fail), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .pwm_enable(pwm_enable), .direct_in(direct_in), .status_read_select(status_read_select),
    .watchdog_toggle_bit(watchdog_toggle_bit), .chan_on(chan_on), .reduced_lamp_profile(),
    .duty_cycle_field(duty_cycle_field), .switch_delay_field(), .slew_select(),
    .retry_counter_disable(), .retry_disable(), .short_to_battery_disable(),
    .on_openload_mode(), .off_openload_disable(), .sense_ratio_select(), .alt_lamp_profile(),
    .cooling_curve(), .inrush_curve(), .high_level_swap(), .steady_limit(),
    .overcurrent_mode_select(), .output_pwm_state(output_pwm_state),
    .output_switching_config(output_switching_config),
    .output_fault_config(output_fault_config),
    .output_overcurrent_config(output_overcurrent_config)
  );

  function automatic logic [15:0] mk(logic w, logic [1:0] c, logic [2:0] r, logic [8:0] d);
    return {w, c, r, 1'b0, d};
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] c, input logic [2:0] r, input logic [8:0] d, input logic w);
    i_host.send({32'h0, mk(w, c, r, d)}, 16);
    settle(6);
  endtask

  task automatic chk_all();
    for (int c = 0; c < NUM_CHAN; c++) begin
      `CHK("pwm", ep[c], output_pwm_state[c*DATA_W+:DATA_W])
      `CHK("sw", es[c], output_switching_config[c*DATA_W+:DATA_W])
      `CHK("fault", ef[c], output_fault_config[c*DATA_W+:DATA_W])
      `CHK("oc", eo[c], output_overcurrent_config[c*DATA_W+:DATA_W])
    end
    `CHK("sel", esel, status_read_select)
  endtask

  task automatic chk_on();
    logic [NUM_CHAN-1:0] e;
    for (int i = 0; i < NUM_CHAN; i++) e[i] = ep[i][7] | (direct_in[i] & ~es[i][5] & ~pwm_enable);
    `CHK("on", e, chan_on)
  endtask

  task automatic t_chan();
    logic [1:0] c;
    for (int i = 0; i < NUM_CHAN; i++) begin
      c = i[1:0];
      ep[i] = {c, ~c, 5'h15};
      es[i] = {4'h0, c, 3'h5};
      ef[i] = {2'h0, c, c, c[0], c[1], c[0]};
      eo[i] = {c[0], c, c, c[1], c, c[0]};
      wr(c, REG_PWM_STATE, ep[i], 1'b0);
      wr(c, REG_SWITCHING, es[i], 1'b1);
      wr(c, REG_FAULT, ef[i], 1'b0);
      wr(c, REG_OVERCUR, eo[i], 1'b1);
      chk_all();
    end
  endtask

  task automatic t_status();
    esel = 5'h15;
    wr(2'h3, REG_STATUS_SEL, 9'h015, 1'b1);
    chk_all();
    `CHK("wdog", 1'b1, watchdog_toggle_bit)
    ep[0] = 9'h07F;
    wr(2'h0, REG_PWM_STATE, ep[0], 1'b0);
    wr(2'h1, 3'h5, 9'h1FF, 1'b0);
    chk_all();
    `CHK("wdog", 1'b0, watchdog_toggle_bit)
  endtask

  task automatic t_frames();
    i_host.send({32'h0, mk(1'b0, 2'h1, REG_PWM_STATE, 9'h0AA)}, 15);
    settle(6);
    i_host.send({32'h0, mk(1'b0, 2'h1, REG_PWM_STATE, 9'h0AA)}, 17);
    settle(6);
    chk_all();
    ep[2] = 9'h0DD;
    i_host.send({16'h0, mk(1'b0, 2'h1, REG_PWM_STATE, 9'h0CC),
                 mk(1'b0, 2'h2, REG_PWM_STATE, ep[2])}, 32);
    settle(6);
    chk_all();
  endtask

  task automatic t_direct();
    for (int k = 0; k < 3; k++) begin
      direct_in = (k == 1) ? 4'h0 : 4'hF;
      if (k == 2) begin
        es[0][5] = 1'b1;
        wr(2'h0, REG_SWITCHING, es[0], 1'b0);
      end
      settle(4);
      chk_on();
    end
    pwm_enable = 1'b1;
    settle(4);
    chk_on();
    `CHK("duty", {ep[3][6:0], ep[2][6:0], ep[1][6:0], ep[0][6:0]}, duty_cycle_field)
    pwm_enable = 1'b0;
    settle(4);
    `CHK("duty", 28'h0, duty_cycle_field)
  endtask

  task automatic t_fail();
    supply_fail = 1'b1;
    settle(4);
    supply_fail = 1'b0;
    settle(3);
    ep = '{default: '0};
    es = '{default: '0};
    ef = '{default: '0};
    eo = '{default: '0};
    esel = '0;
    chk_all();
    settle(6);
    chk_all();
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    settle(4);
    rstn = 1'b1;
    chk_all();
    t_chan();
    t_status();
    t_frames();
    t_direct();
    t_fail();
    test_done();
  end

  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule

`default_nettype wire
